// file: src/sbst_pkg.sv
// package: constants, states and state record of the memory boundary-scan port
package sbst_pkg;

    localparam int IR_W        = 3;
    localparam int ID_W        = 32;
    localparam int BND_W       = 107;
    localparam int OE_CELL     = 47;

    // identification field positions
    localparam int ID_REV_HI   = 31;
    localparam int ID_REV_LO   = 29;
    localparam int ID_PART_HI  = 28;
    localparam int ID_PART_LO  = 12;
    localparam int ID_MAKER_HI = 11;
    localparam int ID_MAKER_LO = 1;
    localparam int ID_PRESENT  = 0;

    // opcodes
    localparam logic [2:0] OP_EXTEST  = 3'h0;
    localparam logic [2:0] OP_IDCODE  = 3'h1;
    localparam logic [2:0] OP_SAMPLEZ = 3'h2;
    localparam logic [2:0] OP_SAMPLE  = 3'h4;
    localparam logic [2:0] OP_BYPASS  = 3'h7;

    // reset and capture values
    localparam logic [BND_W-1:0] BND_UPD_RST = {59'h0, 1'b1, 47'h0};
    localparam logic             BYP_CAPTURE = 1'b0;

    // timing: the test clock high and low phases each last at least this long
    localparam int CLK_PERIOD_NS = 20;
    localparam int TCK_PHASE_NS  = 20;
    localparam int TCK_PHASE_CYC = (TCK_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES   = 2;

    typedef enum logic [3:0] {
        ST_TLR, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
        ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sbst_state_t;

    typedef enum logic [1:0] {
        SEL_BYP, SEL_ID, SEL_BND
    } sbst_dr_sel_t;

    typedef struct packed {
        sbst_state_t       st;
        logic              tck_prev;
        logic [IR_W-1:0]   ir;
        logic [IR_W-1:0]   ir_sh;
        logic              byp;
        logic [ID_W-1:0]   id_sh;
        logic [BND_W-1:0]  bnd_sh;
        logic [BND_W-1:0]  bnd_upd;
        logic              tdo;
        logic              tdo_oe;
        logic              q_oe;
        logic              ext;
    } sbst_regs_t;

    // pins sampled from outside the clock domain
    typedef struct packed {
        logic              tck;
        logic              tms;
        logic              tdi;
        logic [BND_W-1:0]  ring;
    } sbst_pins_t;

endpackage

// file: src/sbst_sync.sv
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module sbst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// file: src/sbst_top.sv
// boundary-scan test port of a burst memory, sampled on the system clock
// Operation
// - opcode 000 selects external test and captures the pin ring into the boundary register.
// - opcode 001 captures the fixed 32-bit identity into a serial path, memory untouched.
// - opcode 010 captures pins, shifts the 107-bit boundary register and floats all outputs.
// - opcode 100 captures the pin ring and shifts the boundary register, memory untouched.
// - opcode 111 puts the one-bit passthrough between serial input and output.
// - identity holds revision 31:29, part type 28:12, maker 11:1 and a one in bit 0.
// - the serial output changes only after a falling test-clock edge.
// - cell 47 enables read outputs under external test, presets to one on reset.
// - the opcode holder takes the identity opcode on reset and in test-logic-reset.
// - the boundary register shifts in at its top cell and out at cell 0.
`timescale 1ns/100ps
module sbst_top
    import sbst_pkg::*;
#(
    parameter logic [2:0]  REV_CODE   = 3'h1,        // arbitrary value
    parameter logic [16:0] PART_CODE  = 17'h0ABCD,   // arbitrary value
    parameter logic [10:0] MAKER_CODE = 11'h155      // arbitrary value
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             tck_in,
    input  wire logic             tms_in,
    input  wire logic             tdi_in,
    input  wire logic [BND_W-1:0] ring_in,
    output logic                  tdo_out,
    output logic                  tdo_oe_out,
    output logic                  q_oe_out,
    output logic                  extest_out,
    output logic      [BND_W-1:0] preload_out
);
    localparam logic [ID_W-1:0] ID_VALUE = {REV_CODE, PART_CODE, MAKER_CODE, 1'b1};

    sbst_regs_t r_q;
    sbst_regs_t r_d;
    sbst_pins_t pin_raw;
    sbst_pins_t pin_s;
    logic       rise;
    logic       fall;
    sbst_dr_sel_t sel;

    assign pin_raw = '{tck: tck_in, tms: tms_in, tdi: tdi_in, ring: ring_in};

    sbst_sync #(
        .W ($bits(sbst_pins_t))
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    function automatic sbst_state_t next_state(input sbst_state_t s, input logic tms);
        case (s)
            ST_TLR:      next_state = tms ? ST_TLR      : ST_IDLE;
            ST_IDLE:     next_state = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = tms ? ST_TLR      : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_TLR;
        endcase
    endfunction

    // unused opcodes fall back to the passthrough so the chain never breaks
    function automatic sbst_dr_sel_t dr_select(input logic [IR_W-1:0] op);
        case (op)
            OP_EXTEST, OP_SAMPLEZ, OP_SAMPLE: dr_select = SEL_BND;
            OP_IDCODE:                        dr_select = SEL_ID;
            default:                          dr_select = SEL_BYP;
        endcase
    endfunction

    assign rise = pin_s.tck & ~r_q.tck_prev;
    assign fall = ~pin_s.tck & r_q.tck_prev;
    assign sel  = dr_select(r_q.ir);

    always_comb begin
        r_d          = r_q;
        r_d.tck_prev = pin_s.tck;
        if (rise) begin
            r_d.st = next_state(r_q.st, pin_s.tms);
            case (r_q.st)
                ST_CAP_IR:   r_d.ir_sh = 3'h1;
                ST_SHIFT_IR: r_d.ir_sh = {pin_s.tdi, r_q.ir_sh[IR_W-1:1]};
                ST_CAP_DR: begin
                    r_d.byp   = BYP_CAPTURE;
                    r_d.id_sh = ID_VALUE;
                    if (sel == SEL_BND) begin
                        // cell 47 has no ball; it reads back its own latch
                        r_d.bnd_sh          = pin_s.ring;
                        r_d.bnd_sh[OE_CELL] = r_q.bnd_upd[OE_CELL];
                    end
                end
                ST_SHIFT_DR: begin
                    r_d.byp   = pin_s.tdi;
                    r_d.id_sh = {pin_s.tdi, r_q.id_sh[ID_W-1:1]};
                    if (sel == SEL_BND) begin
                        r_d.bnd_sh = {pin_s.tdi, r_q.bnd_sh[BND_W-1:1]};
                    end
                end
                default: ;
            endcase
        end
        if (fall) begin
            // new serial bit is presented in the low phase
            r_d.tdo_oe = (r_q.st == ST_SHIFT_IR) || (r_q.st == ST_SHIFT_DR);
            if (r_q.st == ST_SHIFT_IR) begin
                r_d.tdo = r_q.ir_sh[0];
            end else if (r_q.st == ST_SHIFT_DR) begin
                case (sel)
                    SEL_ID:  r_d.tdo = r_q.id_sh[0];
                    SEL_BND: r_d.tdo = r_q.bnd_sh[0];
                    default: r_d.tdo = r_q.byp;
                endcase
            end
            if (r_q.st == ST_UPD_IR) begin
                r_d.ir = r_q.ir_sh;
            end
            if (r_q.st == ST_UPD_DR && sel == SEL_BND) begin
                r_d.bnd_upd = r_q.bnd_sh;
            end
        end
        if (r_q.st == ST_TLR) begin
            r_d.ir               = OP_IDCODE;
            r_d.bnd_upd[OE_CELL] = 1'b1;
        end
        case (r_q.ir)
            OP_EXTEST:  r_d.q_oe = r_q.bnd_upd[OE_CELL];
            OP_SAMPLEZ: r_d.q_oe = 1'b0;
            default:    r_d.q_oe = 1'b1;
        endcase
        r_d.ext = (r_q.ir == OP_EXTEST);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_q         <= '0;
            r_q.st      <= ST_TLR;
            r_q.ir      <= OP_IDCODE;
            r_q.ir_sh   <= 3'h1;
            r_q.bnd_upd <= BND_UPD_RST;
            r_q.q_oe    <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign tdo_out     = r_q.tdo;
    assign tdo_oe_out  = r_q.tdo_oe;
    assign q_oe_out    = r_q.q_oe;
    assign extest_out  = r_q.ext;
    assign preload_out = r_q.bnd_upd;

    // checks
    sequence s_cap_id;
        rise && r_q.st == ST_CAP_DR && r_q.ir == OP_IDCODE;
    endsequence

    sequence s_cap_byp;
        rise && r_q.st == ST_CAP_DR && r_q.ir == OP_BYPASS;
    endsequence

    sequence s_shift_bnd;
        rise && r_q.st == ST_SHIFT_DR && sel == SEL_BND;
    endsequence

    property p_tlr_ir;
        @(posedge clk_in) disable iff (rst_in)
        r_q.st == ST_TLR |=> r_q.ir == OP_IDCODE && r_q.bnd_upd[OE_CELL];
    endproperty
    a_tlr_ir: assert property (p_tlr_ir) else $error("reset state lost id opcode");

    property p_tdo_on_fall;
        @(posedge clk_in) disable iff (rst_in)
        $changed(tdo_out) |-> $past(fall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off fall");

    property p_samplez_float;
        @(posedge clk_in) disable iff (rst_in)
        (r_q.ir == OP_SAMPLEZ) [*2] |-> !q_oe_out;
    endproperty
    a_samplez_float: assert property (p_samplez_float) else $error("outputs not floated");

    property p_extest_oe;
        @(posedge clk_in) disable iff (rst_in)
        r_q.ir == OP_EXTEST ##1 (r_q.ir == OP_EXTEST && $stable(r_q.bnd_upd[OE_CELL]))
            |-> q_oe_out == r_q.bnd_upd[OE_CELL] && extest_out;
    endproperty
    a_extest_oe: assert property (p_extest_oe) else $error("cell 47 not driving oe");

    property p_id_capture;
        @(posedge clk_in) disable iff (rst_in)
        s_cap_id |=> r_q.id_sh == ID_VALUE && r_q.id_sh[ID_PRESENT];
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("identity not captured");

    property p_byp_capture;
        @(posedge clk_in) disable iff (rst_in)
        s_cap_byp |=> r_q.byp == BYP_CAPTURE;
    endproperty
    a_byp_capture: assert property (p_byp_capture) else $error("bypass not cleared");

    property p_bnd_shift;
        @(posedge clk_in) disable iff (rst_in)
        s_shift_bnd |=> r_q.bnd_sh[BND_W-1] == $past(pin_s.tdi)
            && r_q.bnd_sh[BND_W-2:0] == $past(r_q.bnd_sh[BND_W-1:1]);
    endproperty
    a_bnd_shift: assert property (p_bnd_shift) else $error("boundary shift wrong");

    property p_fsm_escape;
        @(posedge clk_in) disable iff (rst_in)
        rise && pin_s.tms && r_q.st == ST_SEL_IR |=> r_q.st == ST_TLR;
    endproperty
    a_fsm_escape: assert property (p_fsm_escape) else $error("no return to reset");

    property p_sample_oe;
        @(posedge clk_in) disable iff (rst_in)
        (r_q.ir == OP_SAMPLE) [*2] |-> q_oe_out && !extest_out;
    endproperty
    a_sample_oe: assert property (p_sample_oe) else $error("sample disturbed outputs");
endmodule

// file: test/sbst_ctl_model.sv
// test controller model: drives the test clock, mode select and serial input
`timescale 1ns/100ps
module sbst_ctl_model (
    input  wire logic clk_in,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    initial begin
        tck_out <= 1'b0;
        tms_out <= 1'b1;
        tdi_out <= 1'b0;
    end

    // one 160 ns test-clock period; tdo is read late in the high phase, where it stands
    task automatic cyc(input logic tms, input logic tdi, output logic tdo);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (4) @(posedge clk_in);
        tck_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        tdo = tdo_oe_in ? tdo_in : 1'bx;
        tck_out <= 1'b0;
    endtask

    // outside shifts the data line toggles so no stale bit can be mistaken for data
    task automatic nav(input logic tms);
        logic d;
        cyc(tms, ~tdi_out, d);
    endtask

    task automatic tap_reset();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask

    // from idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [119:0] din,
                        output logic [119:0] dout);
        dout = '0;
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++) cyc(i == n - 1, din[i], dout[i]);
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule

// file: test/tb.sv
// self-checking bench for the memory boundary-scan port
`timescale 1ns/100ps
module tb;
    import sbst_pkg::*;
    localparam logic [2:0]   REV    = 3'h5;     // arbitrary value
    localparam logic [16:0]  PART   = 17'h1234; // arbitrary value
    localparam logic [10:0]  MKR    = 11'h02A;  // arbitrary value
    localparam logic [31:0]  ID_EXP = {REV, PART, MKR, 1'b1};
    localparam logic [119:0] PAT    = {30{4'h6}};
    localparam logic [107:0] RING   = {27{4'h3}};
    typedef struct packed {
        logic [2:0] op;
        logic [6:0] len;
    } sbst_row_t;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             tck, tms, tdi, tdo, tdo_oe, q_oe, ext;
    logic [BND_W-1:0] ring, pre, pre_exp;
    logic [119:0]     din, dout, cap;
    int               err_total = 0;
    int               n_compared = 0;
    // only defined opcodes are ever loaded
    sbst_row_t rows [5] = '{'{OP_SAMPLE, 7'd107}, '{OP_EXTEST, 7'd107},
        '{OP_SAMPLEZ, 7'd107}, '{OP_IDCODE, 7'd32}, '{OP_BYPASS, 7'd1}};

    always #10 clk = ~clk;

    sbst_top #(.REV_CODE(REV), .PART_CODE(PART), .MAKER_CODE(MKR)) uut (
        .clk_in(clk), .rst_in(rst), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .ring_in(ring), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .q_oe_out(q_oe),
        .extest_out(ext), .preload_out(pre));
    sbst_ctl_model m (.clk_in(clk), .tdo_in(tdo), .tdo_oe_in(tdo_oe),
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

    task automatic chk(input logic [119:0] s, input logic [119:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // whole run needs about 6550 clocks
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end

    initial begin
        ring <= RING[106:0];
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(120'({tdo_oe, q_oe, ext}), 120'(3'b010));
        chk(120'(pre), 120'(BND_UPD_RST));
        repeat (3) @(posedge clk);
        m.tap_reset();
        m.scan(1'b0, 32, PAT, dout);
        chk(120'(dout[31:0]), 120'(ID_EXP));
        $display("test reset and identity done");
        pre_exp = BND_UPD_RST;
        foreach (rows[r]) begin
            din = (r % 2 == 1) ? ~PAT : PAT;
            m.scan(1'b1, 3, 120'(rows[r].op), dout);
            chk(120'(dout[2:0]), 120'(3'b001));
            chk(120'(ext), 120'(rows[r].op == OP_EXTEST));
            chk(120'(q_oe), 120'(rows[r].op == OP_EXTEST ? pre_exp[OE_CELL]
                : rows[r].op != OP_SAMPLEZ));
            cap = 120'(RING[106:0]);
            cap[OE_CELL] = pre_exp[OE_CELL];
            if (rows[r].len == 7'd32) cap = 120'(ID_EXP);
            if (rows[r].len == 7'd1) cap = '0;
            m.scan(1'b0, 120, din, dout);
            chk(dout, cap | (din << rows[r].len));
            if (rows[r].len == 7'd107) pre_exp = din[119:13];
            chk(120'(pre), 120'(pre_exp));
            if (rows[r].op == OP_EXTEST) chk(120'(q_oe), 120'(pre_exp[OE_CELL]));
            $display("test opcode %0d done", rows[r].op);
        end
        // cell 47 now latched low: outputs float under external test until test reset
        m.scan(1'b1, 3, 120'(OP_EXTEST), dout);
        chk(120'({q_oe, ext}), 120'(2'b01));
        m.tap_reset();
        chk(120'({q_oe, ext, pre[OE_CELL]}), 120'(3'b101));
        m.scan(1'b0, 32, PAT, dout);
        chk(120'(dout[31:0]), 120'(ID_EXP));
        $display("test test-logic-reset done");
        // reset in mid-run with outputs floated must restore the power-up state
        m.scan(1'b1, 3, 120'(OP_SAMPLEZ), dout);
        chk(120'(q_oe), 120'(1'b0));
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(120'({tdo_oe, q_oe, ext}), 120'(3'b010));
        chk(120'(pre), 120'(BND_UPD_RST));
        repeat (3) @(posedge clk);
        m.tap_reset();
        m.scan(1'b0, 32, PAT, dout);
        chk(120'(dout[31:0]), 120'(ID_EXP));
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
